/* File: dv/cdf_assertions.sv */
// Checker watching the word link between the controller and the DMA engine
`timescale 1ns/1ps
`include "cdf_defines.svh"
module cdf_assertions (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic tx_req,
  input wire logic tx_wr,
  input wire logic [15:0] tx_data,
  input wire logic [6:0] tx_code,
  input wire logic [4:0] tx_buf,
  input wire logic rx_req,
  input wire logic rx_rd,
  input wire logic [15:0] rx_data,
  input wire logic [6:0] rx_code,
  input wire logic [4:0] rx_buf
);
  logic [3:0] txn_reg;
  logic [3:0] rxn_reg;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // ==========================================
  // Word counters
  // Cleared while idle, so a short message cannot borrow counts from the last one
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !tx_req) begin
      txn_reg <= 4'h0;
    end else if (tx_wr) begin
      txn_reg <= txn_reg + 4'h1;
    end
    if (srst_in || !rx_req) begin
      rxn_reg <= 4'h0;
    end else if (rx_rd) begin
      rxn_reg <= rxn_reg + 4'h1;
    end
  end
  // ==========================================
  // Link properties
  property p_tx_code;
    tx_code == `CDF_EV_TX_A;
  endproperty
  a_tx_code: assert property (p_tx_code) else $error("transmit event code wrong");
  property p_rx_code;
    rx_code == `CDF_EV_RX_A;
  endproperty
  a_rx_code: assert property (p_rx_code) else $error("receive event code wrong");
  property p_tx_first;
    $rose(tx_req) |=> tx_wr;
  endproperty
  a_tx_first: assert property (p_tx_first) else $error("no first transmit word");
  property p_tx_len;
    $rose(tx_req) |-> ##15 tx_req ##1 !tx_req;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("transmit request length wrong");
  property p_tx_cnt;
    $fell(tx_req) |-> txn_reg == 4'h8;
  endproperty
  a_tx_cnt: assert property (p_tx_cnt) else $error("transmit word count wrong");
  property p_rx_first;
    $rose(rx_req) |=> rx_rd;
  endproperty
  a_rx_first: assert property (p_rx_first) else $error("no first receive read");
  property p_rx_cnt;
    $fell(rx_req) |-> rxn_reg == 4'h8;
  endproperty
  a_rx_cnt: assert property (p_rx_cnt) else $error("receive word count wrong");
  property p_tx_gap;
    tx_wr |=> !tx_wr;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("transmit strobes back to back");
  property p_rx_hold;
    rx_req && !rx_rd |=> !rx_req || $stable(rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive word changed unread");
  property p_tx_buf;
    tx_req |=> !tx_req || $stable(tx_buf);
  endproperty
  a_tx_buf: assert property (p_tx_buf) else $error("send buffer changed mid message");
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the data-bit filter and DMA message port
`timescale 1ns/1ps
`include "cdf_defines.svh"
module testbench;
  localparam logic [10:0] fsid_val = 11'h5A3;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fv = 1'b0;
  logic ide = 1'b0;
  logic [10:0] base_identifier_field = 11'h000;
  logic [3:0] dlc = 4'h0;
  logic [127:0] words = 128'h0;
  logic [127:0] w_exp = 128'h0;
  logic [23:0] data = 24'h000000;
  logic [7:0] start = 8'h40;
  logic [7:0] maddr = 8'h00;
  logic [15:0] mwdata = 16'h0000;
  logic mwr = 1'b0;
  logic mrd = 1'b0;
  logic [6:0] txsel = 7'h47;
  logic [15:0] rdata;
  logic [15:0] mrdata;
  logic [127:0] txmsg;
  logic txv;
  logic irq;
  logic rdp = 1'b0;
  logic mrdp = 1'b0;
  logic [31:0] seed = 32'hC91FA3ED;
  logic [15:0] qr[$];
  logic [15:0] qm[$];
  logic [127:0] qt[$];
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int rxb = 0;
  cdf_if link_if ();
  cdf_dev #(.SECOND(1'b0)) cdf_dev_inst (.sys_clk_in(sys_clk), .srst_in(srst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .rx_frame_valid_in(fv),
    .rx_sid_in(base_identifier_field), .rx_ide_in(ide), .rx_dlc_in(dlc), .rx_words_in(words), .rx_data_in(data),
    .tx_msg_out(txmsg), .tx_msg_valid_out(txv), .irq_out(irq), .link(link_if));
  cdf_dma cdf_dma_inst (.sys_clk_in(sys_clk), .srst_in(srst), .dma_start_in(start), .tx_select_in(txsel),
    .rx_select_in(`CDF_EV_RX_A), .ram_addr_in(maddr), .ram_wdata_in(mwdata), .ram_wr_in(mwr),
    .ram_rd_in(mrd), .ram_rdata_out(mrdata), .link(link_if));
  cdf_assertions cdf_assertions_inst (.sys_clk_in(sys_clk), .srst_in(srst), .tx_req(link_if.tx_req),
    .tx_wr(link_if.tx_wr), .tx_data(link_if.tx_data), .tx_code(link_if.tx_code), .tx_buf(link_if.tx_buf),
    .rx_req(link_if.rx_req), .rx_rd(link_if.rx_rd), .rx_data(link_if.rx_data), .rx_code(link_if.rx_code),
    .rx_buf(link_if.rx_buf));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic ref_acc(input logic [4:0] n0, input logic [3:0] l, input logic [23:0] d,
      input logic [17:0] e);
    int n;
    n = (n0 > 5'h12) ? 18 : int'(n0);
    if (l == 4'h0) n = 0;
    else if (l == 4'h1 && n > 8) n = 8;
    else if (l == 4'h2 && n > 16) n = 16;
    for (int i = 0; i < n; i++) if (d[23 - i] !== e[17 - i]) return 1'b0;
    return 1'b1;
  endfunction
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    chk("pending", 128'h0, 128'(qr.size() + qm.size() + qt.size()));
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================
  // Drivers: one strobe cycle, then a quiet edge
  task automatic op(input bit m, input bit w, input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    if (m) begin
      maddr <= a;
      mwdata <= d;
      mwr <= w;
      mrd <= !w;
    end else begin
      addr <= a[3:0];
      wdata <= d;
      wr <= w;
      rd <= !w;
    end
    @(posedge sys_clk);
    {wr, rd, mwr, mrd} <= 4'h0;
  endtask
  task automatic rdx(input bit m, input logic [7:0] a, input logic [15:0] e);
    if (m) qm.push_back(e);
    else qr.push_back(e);
    op(m, 1'b0, a, 16'h0000);
  endtask
  task automatic frame(input logic [10:0] s, input logic [3:0] l, input logic [23:0] d, input bit x);
    w_exp = {rnd(), rnd(), rnd(), rnd()};
    @(posedge sys_clk);
    base_identifier_field <= s;
    dlc <= l;
    data <= d;
    ide <= x;
    words <= w_exp;
    fv <= 1'b1;
    @(posedge sys_clk);
    fv <= 1'b0;
  endtask
  // Flips data bit j (18 flips none); accepted frames are traced into the RAM ring
  task automatic filt(input logic [4:0] n, input logic [3:0] l, input int j, input logic [10:0] s, input bit x);
    logic [23:0] d;
    logic [17:0] e;
    logic acc;
    d = 24'(rnd());
    e = d[23:6] ^ (18'h20000 >> j);
    acc = (s == fsid_val) && (x || ref_acc(n, l, d, e));
    op(0, 1, `CDF_A_CTRL2, {11'h000, n});
    op(0, 1, `CDF_A_FEIDL, e[15:0]);
    op(0, 1, `CDF_A_FEIDH, {14'h0000, e[17:16]});
    frame(s, l, d, x);
    repeat (20) @(posedge sys_clk);
    rdx(0, `CDF_A_STS, acc ? 16'h0002 : 16'h0004);
    op(0, 1, `CDF_A_STS, 16'h000F);
    if (acc) for (int i = 0; i < 8; i++) rdx(1, 8'(start + rxb * 8 + i), w_exp[16 * i +: 16]);
    if (acc) rxb = (rxb == 3) ? 0 : rxb + 1;
  endtask
  // ==========================================
  // Result monitor
  always @(posedge sys_clk) begin
    rdp <= rd;
    mrdp <= mrd;
    if (rdp) chk("reg_rdata_out", {112'h0, qr.pop_front()}, {112'h0, rdata});
    if (mrdp) chk("ram_rdata_out", {112'h0, qm.pop_front()}, {112'h0, mrdata});
    if (txv) chk("tx_msg_out", qt.pop_front(), txmsg);
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rdx(0, `CDF_A_STS, 16'h0000);
    rdx(0, 8'h0A, 16'h0000);
    op(0, 1, `CDF_A_QCTRL, 16'hFFFF);
    rdx(0, `CDF_A_QCTRL, 16'hE000);
    op(0, 1, `CDF_A_QCTRL, 16'h0000);
    op(0, 1, `CDF_A_FSID, {4'h1, 1'b0, fsid_val});
    filt(5'h03, 4'h8, 2, fsid_val, 1'b0);
    filt(5'h03, 4'h8, 3, fsid_val, 1'b0);
    filt(5'h08, 4'h8, 18, fsid_val ^ 11'h001, 1'b0);
    filt(5'h12, 4'h8, 17, fsid_val, 1'b0);
    filt(5'h12, 4'h8, 18, fsid_val, 1'b0);
    filt(5'h1F, 4'h8, 17, fsid_val, 1'b0);
    filt(5'h13, 4'h8, 18, fsid_val, 1'b0);
    filt(5'h11, 4'h2, 15, fsid_val, 1'b0);
    filt(5'h14, 4'h2, 16, fsid_val, 1'b0);
    filt(5'h09, 4'h1, 7, fsid_val, 1'b0);
    filt(5'h0C, 4'h1, 8, fsid_val, 1'b0);
    filt(5'h05, 4'h0, 0, fsid_val, 1'b0);
    filt(5'h03, 4'h8, 0, fsid_val, 1'b1);
    for (int i = 0; i < 8; i++) begin
      w_exp[16 * i +: 16] = 16'(rnd());
      op(1, 1, 8'(start + 40 + i), w_exp[16 * i +: 16]);
    end
    for (int i = 0; i < 8; i++) rdx(1, 8'(start + 40 + i), w_exp[16 * i +: 16]);
    // Buffer 5 goes out word 0 first, so the collected message equals the RAM image
    qt.push_back(w_exp);
    op(0, 1, `CDF_A_MSK, 16'h0001);
    // Selector must match before the request rises, else the first-word check would fire
    txsel <= `CDF_EV_TX_A;
    op(0, 1, `CDF_A_BPC, 16'h000D);
    rdx(0, `CDF_A_BPC, 16'h000D);
    // Frame lands mid-message: accepted but lost as an overrun
    frame(fsid_val, 4'h8, 24'h000000, 1'b1);
    repeat (25) @(posedge sys_clk);
    rdx(0, `CDF_A_STS, 16'h0009);
    rdx(0, `CDF_A_BPC, 16'h0005);
    @(negedge sys_clk);
    chk("irq_out", 128'h1, {127'h0, irq});
    op(0, 1, `CDF_A_STS, 16'h0001);
    @(negedge sys_clk);
    chk("irq_out", 128'h0, {127'h0, irq});
    wrap_up();
  end
endmodule

/* File: src/cdf_defines.svh */
// Constants shared by the data-bit filter and DMA message port design
// Overview of operation
// R01: Compare first n data bits against extension bits
// R02: Accept only on base id and bit match
// R03: Counts above 18 stop at bit eighteen
// R04: Two-byte frames stop comparing at bit sixteen
// R05: One-byte frames stop comparing at bit eight
// R06: Empty frames compare base identifier only
// R07: Buffer count from queue control bits 15:13
// R08: DMA holds start address, moves words alone
// R09: One DMA channel each for send, receive
// R10: Channel selectors hold event codes 34,70,55,71
// R11: Software sets send request bit 3 to send
// R12: Transmit request makes DMA write transmit port
// R13: Every sent message is eight words
// R14: Received message raises request, DMA reads eight
// R15: Data-bit filter only for standard-type setups
// R16: Next word request only after previous word
`ifndef CDF_DEFINES_SVH
`define CDF_DEFINES_SVH
// ==========================================================
// Register offsets
`define CDF_A_CTRL2 4'h0
`define CDF_A_QCTRL 4'h1
`define CDF_A_FSID 4'h2
`define CDF_A_FEIDL 4'h3
`define CDF_A_FEIDH 4'h4
`define CDF_A_BPC 4'h5
`define CDF_A_STS 4'h6
`define CDF_A_MSK 4'h7
// ==========================================================
// Field positions
`define CDF_QC_BS_HI 15
`define CDF_QC_BS_LO 13
`define CDF_FSID_EXT 11
`define CDF_FSID_MTM 12
`define CDF_BPC_SEND 3
`define CDF_EV_TXDONE 0
`define CDF_EV_RXDONE 1
`define CDF_EV_REJECT 2
`define CDF_EV_OVERRUN 3
// ==========================================================
// Filter limits and counts
`define CDF_DBC_MAX 5'h12
`define CDF_DBC_TWO 5'h10
`define CDF_DBC_ONE 5'h08
`define CDF_DBC_NONE 5'h00
`define CDF_DLC_ZERO 4'h0
`define CDF_DLC_ONE 4'h1
`define CDF_DLC_TWO 4'h2
`define CDF_EID_BITS 18
`define CDF_LAST_WORD 3'h7
// ==========================================================
// Event codes for the request selectors
`define CDF_EV_RX_A 7'h22
`define CDF_EV_TX_A 7'h46
`define CDF_EV_RX_B 7'h37
`define CDF_EV_TX_B 7'h47
`endif

/* File: src/cdf_dev.sv */
// Controller end: registers, filtering and eight-word message port
`timescale 1ns/1ps
`include "cdf_defines.svh"
module cdf_dev #(
  parameter bit SECOND = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic rx_frame_valid_in,
  input wire logic [10:0] rx_sid_in,
  input wire logic rx_ide_in,
  input wire logic [3:0] rx_dlc_in,
  input wire logic [127:0] rx_words_in,
  input wire logic [23:0] rx_data_in,
  output logic [127:0] tx_msg_out,
  output logic tx_msg_valid_out,
  output logic irq_out,
  cdf_if.dev link
);
  cdf_pkg::cdf_dev_state_t s_reg;
  cdf_pkg::cdf_dev_state_t s_next;
  logic accept;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [4:0] rx_last;

  // ==========================================================
  // Register read mux
  function automatic logic [15:0] rd_mux(input logic [3:0] a, input cdf_pkg::cdf_dev_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      `CDF_A_CTRL2: begin
        v[4:0] = s.dbc;
      end
      `CDF_A_QCTRL: begin
        v[`CDF_QC_BS_HI:`CDF_QC_BS_LO] = s.bsz;
      end
      `CDF_A_FSID: begin
        v[10:0] = s.fsid;
        v[`CDF_FSID_EXT] = s.fext;
        v[`CDF_FSID_MTM] = s.mtm;
      end
      `CDF_A_FEIDL: begin
        v = s.feid[15:0];
      end
      `CDF_A_FEIDH: begin
        v[1:0] = s.feid[17:16];
      end
      `CDF_A_BPC: begin
        v[3:0] = s.bpc;
      end
      `CDF_A_STS: begin
        v[3:0] = s.sts;
      end
      `CDF_A_MSK: begin
        v[3:0] = s.msk;
      end
      default: begin
        v = 16'h0000;
      end
    endcase
    return v;
  endfunction

  // ==========================================================
  // Filter
  cdf_filter cdf_filter_inst (
    .data_bit_count_in(s_reg.dbc),
    .rx_sid_in(rx_sid_in),
    .rx_ide_in(rx_ide_in),
    .rx_dlc_in(rx_dlc_in),
    .rx_data_in(rx_data_in),
    .base_identifier_field_in(s_reg.fsid),
    .extension_identifier_field_in(s_reg.feid),
    .filter_extended_select_in(s_reg.fext),
    .mask_type_match_in(s_reg.mtm),
    .accept_out(accept)
  );

  // Ring of receive buffers; field value k gives 4*(k+1) buffers
  assign rx_last = {s_reg.bsz, 2'h3}; // R07

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    ev = 4'h0;
    clr = 4'h0;
    s_next.txv = 1'b0;
    s_next.rdata = 16'h0000;
    if (reg_rd_in) begin
      s_next.rdata = rd_mux(reg_addr_in, s_reg);
    end
    case (s_reg.st)
      cdf_pkg::CDF_IDLE: begin
        s_next.cnt = 3'h0;
        if (rx_frame_valid_in && accept) begin
          s_next.st = cdf_pkg::CDF_RX; // R14
          s_next.words = rx_words_in;
        end else if (s_reg.bpc[`CDF_BPC_SEND]) begin
          s_next.st = cdf_pkg::CDF_TX; // R11
        end
      end
      cdf_pkg::CDF_TX: begin
        // One word per strobe; the request stays up until the eighth lands
        if (link.tx_wr) begin
          s_next.words = {link.tx_data, s_reg.words[127:16]}; // R16
          s_next.cnt = 3'(s_reg.cnt + 3'h1);
          if (s_reg.cnt == `CDF_LAST_WORD) begin
            s_next.st = cdf_pkg::CDF_IDLE; // R13
            s_next.txv = 1'b1;
            s_next.bpc[`CDF_BPC_SEND] = 1'b0;
            ev[`CDF_EV_TXDONE] = 1'b1;
          end
        end
      end
      cdf_pkg::CDF_RX: begin
        if (link.rx_rd) begin
          s_next.words = {16'h0000, s_reg.words[127:16]}; // R16
          s_next.cnt = 3'(s_reg.cnt + 3'h1);
          if (s_reg.cnt == `CDF_LAST_WORD) begin
            s_next.st = cdf_pkg::CDF_IDLE; // R14
            ev[`CDF_EV_RXDONE] = 1'b1;
            if (s_reg.rxbuf >= rx_last) begin
              s_next.rxbuf = 5'h00; // R07
            end else begin
              s_next.rxbuf = 5'(s_reg.rxbuf + 5'h01);
            end
          end
        end
      end
      default: begin
        s_next.st = cdf_pkg::CDF_IDLE;
      end
    endcase
    if (rx_frame_valid_in && !accept) begin
      ev[`CDF_EV_REJECT] = 1'b1;
    end
    // A frame that passes while a message is still moving is dropped
    if (rx_frame_valid_in && accept && s_reg.st != cdf_pkg::CDF_IDLE) begin
      ev[`CDF_EV_OVERRUN] = 1'b1;
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        `CDF_A_CTRL2: begin
          s_next.dbc = reg_wdata_in[4:0];
        end
        `CDF_A_QCTRL: begin
          s_next.bsz = reg_wdata_in[`CDF_QC_BS_HI:`CDF_QC_BS_LO];
        end
        `CDF_A_FSID: begin
          s_next.fsid = reg_wdata_in[10:0];
          s_next.fext = reg_wdata_in[`CDF_FSID_EXT];
          s_next.mtm = reg_wdata_in[`CDF_FSID_MTM];
        end
        `CDF_A_FEIDL: begin
          s_next.feid[15:0] = reg_wdata_in;
        end
        `CDF_A_FEIDH: begin
          s_next.feid[17:16] = reg_wdata_in[1:0];
        end
        `CDF_A_BPC: begin
          // Software write lands after the hardware clear, so a fresh request survives
          s_next.bpc = reg_wdata_in[3:0]; // R11
        end
        `CDF_A_STS: begin
          clr = reg_wdata_in[3:0];
        end
        `CDF_A_MSK: begin
          s_next.msk = reg_wdata_in[3:0];
        end
        default: begin
          clr = 4'h0;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    s_next.sts = (s_reg.sts & ~clr) | ev;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign link.tx_req = (s_reg.st == cdf_pkg::CDF_TX); // R12
  assign link.rx_req = (s_reg.st == cdf_pkg::CDF_RX); // R14
  assign link.rx_data = s_reg.words[15:0];
  assign link.tx_buf = {2'h0, s_reg.bpc[2:0]};
  assign link.rx_buf = s_reg.rxbuf;
  assign link.tx_code = SECOND ? `CDF_EV_TX_B : `CDF_EV_TX_A; // R10
  assign link.rx_code = SECOND ? `CDF_EV_RX_B : `CDF_EV_RX_A; // R10
  assign reg_rdata_out = s_reg.rdata;
  assign tx_msg_out = s_reg.words;
  assign tx_msg_valid_out = s_reg.txv;
  assign irq_out = |(s_reg.sts & s_reg.msk);
endmodule

/* File: src/cdf_dma.sv */
// DMA end: two channels moving eight-word messages through its RAM
`timescale 1ns/1ps
`include "cdf_defines.svh"
module cdf_dma (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] dma_start_in,
  input wire logic [6:0] tx_select_in,
  input wire logic [6:0] rx_select_in,
  input wire logic [7:0] ram_addr_in,
  input wire logic [15:0] ram_wdata_in,
  input wire logic ram_wr_in,
  input wire logic ram_rd_in,
  output logic [15:0] ram_rdata_out,
  cdf_if.dma link
);
  cdf_pkg::cdf_dma_state_t s_reg;
  cdf_pkg::cdf_dma_state_t s_next;
  logic [15:0] mem [0:255];
  logic [7:0] tx_addr;
  logic [7:0] rx_addr;

  function automatic logic [7:0] word_addr(input logic [7:0] base, input logic [4:0] bn, input logic [2:0] w);
    return 8'(base + {bn, w}); // R08
  endfunction

  assign tx_addr = word_addr(dma_start_in, link.tx_buf, s_reg.tx_cnt);
  assign rx_addr = word_addr(dma_start_in, link.rx_buf, s_reg.rx_cnt);

  // ==========================================================
  // Channels
  always_comb begin
    s_next = s_reg;
    s_next.txw = 1'b0;
    s_next.rxr = 1'b0;
    s_next.rdata = 16'h0000;
    if (ram_rd_in) begin
      s_next.rdata = mem[ram_addr_in];
    end
    // Gap cycle lets the controller drop its request after the last word
    case (s_reg.tx_st)
      cdf_pkg::CDF_CH_IDLE: begin
        if (link.tx_req && link.tx_code == tx_select_in) begin
          s_next.txd = mem[tx_addr]; // R12
          s_next.txw = 1'b1; // R09
          s_next.tx_cnt = 3'(s_reg.tx_cnt + 3'h1);
          s_next.tx_st = cdf_pkg::CDF_CH_GAP; // R16
        end
      end
      default: begin
        s_next.tx_st = cdf_pkg::CDF_CH_IDLE;
      end
    endcase
    case (s_reg.rx_st)
      cdf_pkg::CDF_CH_IDLE: begin
        if (link.rx_req && link.rx_code == rx_select_in) begin
          s_next.rxr = 1'b1; // R09
          s_next.rx_st = cdf_pkg::CDF_CH_GAP; // R16
        end
      end
      default: begin
        s_next.rx_cnt = 3'(s_reg.rx_cnt + 3'h1); // R14
        s_next.rx_st = cdf_pkg::CDF_CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Receive channel wins the RAM write port over the CPU
  always_ff @(posedge sys_clk_in) begin
    if (s_reg.rxr) begin
      mem[rx_addr] <= link.rx_data; // R14
    end else if (ram_wr_in) begin
      mem[ram_addr_in] <= ram_wdata_in;
    end
  end

  assign link.tx_wr = s_reg.txw;
  assign link.tx_data = s_reg.txd;
  assign link.rx_rd = s_reg.rxr;
  assign ram_rdata_out = s_reg.rdata;
endmodule

/* File: src/cdf_filter.sv */
// Acceptance filter with leading data-bit comparison
`timescale 1ns/1ps
`include "cdf_defines.svh"
module cdf_filter (
  input wire logic [4:0] data_bit_count_in,
  input wire logic [10:0] rx_sid_in,
  input wire logic rx_ide_in,
  input wire logic [3:0] rx_dlc_in,
  input wire logic [23:0] rx_data_in,
  input wire logic [10:0] base_identifier_field_in,
  input wire logic [17:0] extension_identifier_field_in,
  input wire logic filter_extended_select_in,
  input wire logic mask_type_match_in,
  output logic accept_out
);
  logic [4:0] n;
  logic data_mode;
  logic bits_ok;
  always_comb begin
    n = data_bit_count_in;
    if (n > `CDF_DBC_MAX) begin
      n = `CDF_DBC_MAX; // R03
    end
    if (rx_dlc_in == `CDF_DLC_ZERO) begin
      n = `CDF_DBC_NONE; // R06
    end else if (rx_dlc_in == `CDF_DLC_ONE && n > `CDF_DBC_ONE) begin
      n = `CDF_DBC_ONE; // R05
    end else if (rx_dlc_in == `CDF_DLC_TWO && n > `CDF_DBC_TWO) begin
      n = `CDF_DBC_TWO; // R04
    end
    // Only a standard frame against a standard filter may use the data bits
    data_mode = !rx_ide_in && !filter_extended_select_in && mask_type_match_in &&
                (data_bit_count_in != `CDF_DBC_NONE); // R15
    bits_ok = 1'b1;
    for (int i = 0; i < `CDF_EID_BITS; i++) begin
      if (5'(i) < n && rx_data_in[23 - i] != extension_identifier_field_in[17 - i]) begin
        bits_ok = 1'b0; // R01
      end
    end
    accept_out = (rx_sid_in == base_identifier_field_in) && (!data_mode || bits_ok); // R02
  end
endmodule

/* File: src/cdf_if.sv */
// Message word link between the controller and the DMA engine
`timescale 1ns/1ps
interface cdf_if;
  logic tx_req;
  logic tx_wr;
  logic [15:0] tx_data;
  logic [6:0] tx_code;
  logic [4:0] tx_buf;
  logic rx_req;
  logic rx_rd;
  logic [15:0] rx_data;
  logic [6:0] rx_code;
  logic [4:0] rx_buf;
  modport dev (output tx_req, tx_code, tx_buf, rx_req, rx_data, rx_code, rx_buf, input tx_wr, tx_data, rx_rd);
  modport dma (input tx_req, tx_code, tx_buf, rx_req, rx_data, rx_code, rx_buf, output tx_wr, tx_data, rx_rd);
endinterface

/* File: src/cdf_pkg.sv */
// Types shared by both ends of the message port
package cdf_pkg;
  typedef enum logic [1:0] {CDF_IDLE, CDF_TX, CDF_RX} cdf_dev_st_t;
  typedef enum logic {CDF_CH_IDLE, CDF_CH_GAP} cdf_ch_st_t;
  typedef struct packed {
    cdf_dev_st_t st;
    logic [4:0] dbc;
    logic [2:0] bsz;
    logic [10:0] fsid;
    logic fext;
    logic mtm;
    logic [17:0] feid;
    logic [3:0] bpc;
    logic [3:0] sts;
    logic [3:0] msk;
    logic [4:0] rxbuf;
    logic [2:0] cnt;
    logic [127:0] words;
    logic [15:0] rdata;
    logic txv;
  } cdf_dev_state_t;
  typedef struct packed {
    cdf_ch_st_t tx_st;
    cdf_ch_st_t rx_st;
    logic [2:0] tx_cnt;
    logic [2:0] rx_cnt;
    logic [15:0] txd;
    logic txw;
    logic rxr;
    logic [15:0] rdata;
  } cdf_dma_state_t;
endpackage
